// [design/hdlcm_fifo.sv]
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module hdlcm_fifo #(
  parameter int W = 3,
  parameter int D = 16
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 in_valid_i,
  output logic                      in_ready_o,
  input  wire logic [W-1:0]         in_data_i,
  output logic                      out_valid_o,
  input  wire logic                 out_ready_i,
  output logic [W-1:0]              out_data_o,
  output logic [$clog2(D):0]        level_o
);

  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic [AW:0]  next_wr_ptr;
  logic [AW:0]  next_rd_ptr;
  logic         push;
  logic         pop;

  // ------------------------------------------------------------
  // Pointers
  // ------------------------------------------------------------
  always_comb begin
    level_o     = wr_ptr - rd_ptr;
    in_ready_o  = (level_o != (AW+1)'(D));
    out_valid_o = (level_o != '0);
    push        = in_valid_i & in_ready_o;
    pop         = out_valid_o & out_ready_i;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    out_data_o  = mem[rd_ptr[AW-1:0]];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage needs no reset; words are only read once written.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

endmodule // hdlcm_fifo

// [design/hdlcm_mapper.sv]
// HDLC time-slot, bit-mask and frame-parity mapper with Wishbone registers.
//
// Contract
// - Channel 1 frame filter code 00 takes all frames, 01 odd only, 10 even only.
// - Channel 2 frame filter decodes 00 all, 01 odd only, 10 even only.
// - Channel 3 frame filter decodes 00 all, 01 odd only, 10 even only.
// - Frames 1,3,.. are odd and 2,4,.. even; a multiframe starts odd; both directions.
// - Channel 1 uses bit position x of its slots only when mask bit x is one.
// - Channel 1 slots come from separate transmit and receive slot enable words.
// - One mask per channel serves both directions and resets to all ones.
// - Channel 2 uses only masked-in bit positions of its single coded slot.
// - Channel 3 uses only masked-in bit positions of its single coded slot.
// - Channel 2 slot code 0 selects no slot, codes 1 to 31 select that slot; reset 0.
// - Channel 3 slot code 0 selects no slot, codes 1 to 31 select that slot; reset 0.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ns
module hdlcm_mapper
  import hdlcm_pkg::*;
#(
  parameter int ADR_W  = 12,
  parameter int FIFO_D = HDLCM_FIFO_D
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [ADR_W-1:0]     wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 line_bit_stb_i,
  input  wire logic                 line_frame_start_i,
  input  wire logic                 line_mframe_start_i,
  input  wire logic                 line_rx_bit_i,
  input  wire logic                 line_tx_bit_i,
  output logic                      line_tx_bit_o,
  output logic                      rx_valid_o,
  input  wire logic                 rx_ready_i,
  output logic [1:0]                rx_chan_o,
  output logic                      rx_bit_o,
  input  wire logic [HDLCM_NCH-1:0] tx_bit_i,
  output logic [HDLCM_NCH-1:0]      tx_take_o
);

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [5:0]  frame_parity_select;
  logic [7:0]  bit_mask [HDLCM_NCH];
  logic [4:0]  slot_code_ch2;
  logic [4:0]  slot_code_ch3;
  logic [31:0] tx_slot_enable_ch1;
  logic [31:0] rx_slot_enable_ch1;
  logic        overrun;
  logic [31:0] rd_data;
  logic        ack;

  logic [5:0]  next_frame_parity_select;
  logic [7:0]  next_bit_mask [HDLCM_NCH];
  logic [4:0]  next_slot_code_ch2;
  logic [4:0]  next_slot_code_ch3;
  logic [31:0] next_tx_slot_enable_ch1;
  logic [31:0] next_rx_slot_enable_ch1;
  logic        next_overrun;
  logic [31:0] next_rd_data;
  logic        next_ack;

  // ------------------------------------------------------------
  // Frame position state
  // ------------------------------------------------------------
  logic [7:0]  bit_cnt;
  logic        frame_odd;
  logic        line_tx_bit;
  logic [HDLCM_NCH-1:0] tx_take;
  logic [7:0]  next_bit_cnt;
  logic        next_frame_odd;
  logic        next_line_tx_bit;
  logic [HDLCM_NCH-1:0] next_tx_take;

  logic [7:0]  cur_cnt;
  logic        cur_odd;
  logic [4:0]  cur_slot;
  logic [2:0]  cur_pos;
  logic [HDLCM_NCH-1:0] rx_hit;
  logic [HDLCM_NCH-1:0] tx_hit;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic [HDLCM_FIFO_W-1:0] fifo_in_data;
  logic [HDLCM_FIFO_W-1:0] fifo_out_data;
  logic [$clog2(FIFO_D):0] fifo_level;
  logic        req;
  logic        wr;
  logic [7:0]  idx;
  logic        idx_ok;

  // Picks the one channel that owns this bit; lowest channel first.
  function automatic logic [1:0] hdlcm_first(input logic [HDLCM_NCH-1:0] hit);
    hdlcm_first = 2'h0;
    for (int i = HDLCM_NCH - 1; i >= 0; i--) begin
      if (hit[i]) begin
        hdlcm_first = 2'(i);
      end
    end
  endfunction

  // Byte-lane merge for one register word.
  function automatic logic [31:0] hdlcm_lanes(input logic [31:0] old,
                                              input logic [31:0] dat,
                                              input logic [3:0]  sel);
    for (int b = 0; b < 4; b++) begin
      hdlcm_lanes[b*8 +: 8] = sel[b] ? dat[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // ------------------------------------------------------------
  // Frame position and channel selection
  // ------------------------------------------------------------
  // The line strobes come from framer logic on this same clock, so they
  // are used without synchronisers.
  always_comb begin
    cur_cnt  = line_frame_start_i ? 8'h00 : bit_cnt;
    cur_odd  = frame_odd;
    if (line_mframe_start_i) begin
      cur_odd = 1'b1;
    end else if (line_frame_start_i) begin
      cur_odd = ~frame_odd;
    end
    cur_slot = cur_cnt[7:3];
    // Bits leave each slot most significant first, so position 7 is sent first.
    cur_pos  = 3'h7 - cur_cnt[2:0];

    rx_hit[0] = rx_slot_enable_ch1[cur_slot];
    tx_hit[0] = tx_slot_enable_ch1[cur_slot];
    rx_hit[1] = (slot_code_ch2 != 5'h00) && (slot_code_ch2 == cur_slot);
    tx_hit[1] = rx_hit[1];
    rx_hit[2] = (slot_code_ch3 != 5'h00) && (slot_code_ch3 == cur_slot);
    tx_hit[2] = rx_hit[2];
    for (int c = 0; c < HDLCM_NCH; c++) begin
      rx_hit[c] = rx_hit[c] & bit_mask[c][cur_pos] & line_bit_stb_i;
      tx_hit[c] = tx_hit[c] & bit_mask[c][cur_pos] & line_bit_stb_i;
      if (!hdlcm_parity_ok(frame_parity_select[c*HDLCM_PAR_W +: HDLCM_PAR_W], cur_odd)) begin
        rx_hit[c] = 1'b0;
        tx_hit[c] = 1'b0;
      end
    end

    next_bit_cnt     = bit_cnt;
    next_frame_odd   = frame_odd;
    next_line_tx_bit = line_tx_bit;
    next_tx_take     = '0;
    if (line_bit_stb_i) begin
      next_bit_cnt   = cur_cnt + 8'h01;
      next_frame_odd = cur_odd;
      // Overlapping slots are unsupported; the lowest channel simply wins.
      if (tx_hit != '0) begin
        next_line_tx_bit = tx_bit_i[hdlcm_first(tx_hit)];
        next_tx_take[hdlcm_first(tx_hit)] = 1'b1;
      end else begin
        next_line_tx_bit = line_tx_bit_i;
      end
    end

    fifo_in_valid = (rx_hit != '0);
    fifo_in_data  = {hdlcm_first(rx_hit), line_rx_bit_i};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_cnt     <= 8'h00;
      frame_odd   <= 1'b0;
      line_tx_bit <= 1'b1;
      tx_take     <= '0;
    end else begin
      bit_cnt     <= next_bit_cnt;
      frame_odd   <= next_frame_odd;
      line_tx_bit <= next_line_tx_bit;
      tx_take     <= next_tx_take;
    end
  end

  assign line_tx_bit_o = line_tx_bit;
  assign tx_take_o     = tx_take;

  // ------------------------------------------------------------
  // Receive buffer
  // ------------------------------------------------------------
  // The line cannot be stalled, so a full buffer drops the bit and
  // raises the sticky overrun flag instead.
  hdlcm_fifo #(
    .W (HDLCM_FIFO_W),
    .D (FIFO_D)
  ) u_rx_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in_data),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (fifo_out_data),
    .level_o     (fifo_level)
  );

  assign rx_chan_o = fifo_out_data[2:1];
  assign rx_bit_o  = fifo_out_data[0];

  // ------------------------------------------------------------
  // Wishbone register slave
  // ------------------------------------------------------------
  always_comb begin
    req    = wb_cyc_i & wb_stb_i & ~ack;
    wr     = req & wb_we_i;
    idx    = wb_adr_i[9:2];
    idx_ok = (wb_adr_i[ADR_W-1:10] == '0) && (wb_adr_i[1:0] == 2'h0);

    next_ack                 = req;
    next_rd_data             = 32'h0000_0000;
    next_frame_parity_select = frame_parity_select;
    next_bit_mask            = bit_mask;
    next_slot_code_ch2       = slot_code_ch2;
    next_slot_code_ch3       = slot_code_ch3;
    next_tx_slot_enable_ch1  = tx_slot_enable_ch1;
    next_rx_slot_enable_ch1  = rx_slot_enable_ch1;
    next_overrun             = overrun;

    if (!idx_ok) begin
      next_rd_data = 32'h0000_0000;
    end else if (idx == HDLCM_IDX_PARITY) begin
      next_rd_data = {26'h0, frame_parity_select};
      if (wr && wb_sel_i[0]) begin
        next_frame_parity_select = wb_dat_i[5:0];
      end
    end else if (idx == HDLCM_IDX_MASK1 || idx == HDLCM_IDX_MASK2
                 || idx == HDLCM_IDX_MASK3) begin
      next_rd_data = {24'h0, bit_mask[2'(idx - HDLCM_IDX_MASK1)]};
      if (wr && wb_sel_i[0]) begin
        next_bit_mask[2'(idx - HDLCM_IDX_MASK1)] = wb_dat_i[7:0];
      end
    end else if (idx == HDLCM_IDX_CODE2) begin
      next_rd_data = {27'h0, slot_code_ch2};
      if (wr && wb_sel_i[0]) begin
        next_slot_code_ch2 = wb_dat_i[4:0];
      end
    end else if (idx == HDLCM_IDX_CODE3) begin
      next_rd_data = {27'h0, slot_code_ch3};
      if (wr && wb_sel_i[0]) begin
        next_slot_code_ch3 = wb_dat_i[4:0];
      end
    end else if (idx == HDLCM_IDX_TXEN1) begin
      next_rd_data = tx_slot_enable_ch1;
      if (wr) begin
        next_tx_slot_enable_ch1 = hdlcm_lanes(tx_slot_enable_ch1, wb_dat_i, wb_sel_i);
      end
    end else if (idx == HDLCM_IDX_RXEN1) begin
      next_rd_data = rx_slot_enable_ch1;
      if (wr) begin
        next_rx_slot_enable_ch1 = hdlcm_lanes(rx_slot_enable_ch1, wb_dat_i, wb_sel_i);
      end
    end else if (idx == HDLCM_IDX_STATUS) begin
      next_rd_data[HDLCM_STAT_CNT +: 8] = bit_cnt;
      next_rd_data[HDLCM_STAT_ODD]      = frame_odd;
      next_rd_data[HDLCM_STAT_OVR]      = overrun;
      next_rd_data[HDLCM_STAT_LVL +: $clog2(FIFO_D) + 1] = fifo_level;
      if (wr && wb_sel_i[1] && wb_dat_i[HDLCM_STAT_OVR]) begin
        next_overrun = 1'b0;
      end
    end

    // A drop in the clearing cycle still leaves the flag set.
    if (fifo_in_valid && !fifo_in_ready) begin
      next_overrun = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_parity_select <= HDLCM_RST_PARITY;
      for (int c = 0; c < HDLCM_NCH; c++) begin
        bit_mask[c] <= HDLCM_RST_MASK;
      end
      slot_code_ch2      <= HDLCM_RST_CODE;
      slot_code_ch3      <= HDLCM_RST_CODE;
      tx_slot_enable_ch1 <= HDLCM_RST_SLOTEN;
      rx_slot_enable_ch1 <= HDLCM_RST_SLOTEN;
      overrun            <= 1'b0;
      rd_data            <= 32'h0000_0000;
      ack                <= 1'b0;
    end else begin
      frame_parity_select <= next_frame_parity_select;
      bit_mask            <= next_bit_mask;
      slot_code_ch2       <= next_slot_code_ch2;
      slot_code_ch3       <= next_slot_code_ch3;
      tx_slot_enable_ch1  <= next_tx_slot_enable_ch1;
      rx_slot_enable_ch1  <= next_rx_slot_enable_ch1;
      overrun             <= next_overrun;
      rd_data             <= next_rd_data;
      ack                 <= next_ack;
    end
  end

  assign wb_dat_o = rd_data;
  assign wb_ack_o = ack;

endmodule // hdlcm_mapper

// [design/hdlcm_pkg.sv]
// Shared constants for the HDLC time-slot, bit and frame mapper.
package hdlcm_pkg;

  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [7:0] HDLCM_IDX_PARITY = 8'ha0;
  localparam logic [7:0] HDLCM_IDX_MASK1  = 8'ha1;
  localparam logic [7:0] HDLCM_IDX_MASK2  = 8'ha2;
  localparam logic [7:0] HDLCM_IDX_MASK3  = 8'ha3;
  localparam logic [7:0] HDLCM_IDX_CODE2  = 8'ha4;
  localparam logic [7:0] HDLCM_IDX_CODE3  = 8'ha5;
  localparam logic [7:0] HDLCM_IDX_TXEN1  = 8'hb0;
  localparam logic [7:0] HDLCM_IDX_RXEN1  = 8'hb1;
  localparam logic [7:0] HDLCM_IDX_STATUS = 8'hb2;

  // ------------------------------------------------------------
  // Reset values and field layout
  // ------------------------------------------------------------
  localparam logic [7:0]  HDLCM_RST_MASK   = 8'hff;
  localparam logic [4:0]  HDLCM_RST_CODE   = 5'h00;
  localparam logic [5:0]  HDLCM_RST_PARITY = 6'h00;
  localparam logic [31:0] HDLCM_RST_SLOTEN = 32'h0000_0000;
  localparam int          HDLCM_PAR_W      = 2;
  localparam int          HDLCM_CODE_W     = 5;
  localparam int          HDLCM_STAT_CNT   = 0;
  localparam int          HDLCM_STAT_ODD   = 8;
  localparam int          HDLCM_STAT_OVR   = 9;
  localparam int          HDLCM_STAT_LVL   = 16;

  // ------------------------------------------------------------
  // Frame parity codes and datapath sizes
  // ------------------------------------------------------------
  localparam logic [1:0] HDLCM_PAR_BOTH = 2'h0;
  localparam logic [1:0] HDLCM_PAR_ODD  = 2'h1;
  localparam logic [1:0] HDLCM_PAR_EVEN = 2'h2;
  localparam int         HDLCM_NCH      = 3;
  localparam int         HDLCM_FIFO_W   = 3;
  localparam int         HDLCM_FIFO_D   = 16;

  // Frame filter: the undefined code admits no frame at all.
  function automatic logic hdlcm_parity_ok(input logic [1:0] code,
                                           input logic       odd);
    case (code)
      HDLCM_PAR_BOTH: hdlcm_parity_ok = 1'b1;
      HDLCM_PAR_ODD:  hdlcm_parity_ok = odd;
      HDLCM_PAR_EVEN: hdlcm_parity_ok = ~odd;
      default:        hdlcm_parity_ok = 1'b0;
    endcase
  endfunction

endpackage

// [verif/hdlcm_line_model.sv]
// Behavioural model of the E1 framer side: bit strobes, frame marks and data bits.
`timescale 1ns/1ns
module hdlcm_line_model #(
  parameter int MF = 4
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  output logic            bit_stb_o,
  output logic            frame_start_o,
  output logic            mframe_start_o,
  output logic            rx_bit_o,
  output logic            tx_line_o,
  output logic [2:0]      tx_bits_o
);
  logic       phase;
  logic [7:0] bcnt;
  logic [7:0] pat;
  int         fcnt;

  // Data bits change after every strobe, so a stale sample looks right only where two successive pattern bits agree.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase <= 1'b0;
      bcnt  <= 8'h00;
      fcnt  <= 0;
      pat   <= 8'h5a;
    end else begin
      phase <= ~phase;
      if (phase) begin
        bcnt <= bcnt + 8'h01;
        pat  <= {pat[6:0], pat[7] ^ pat[5] ^ pat[0]};
        if (bcnt == 8'hff) fcnt <= (fcnt + 1) % MF;
      end
    end
  end

  assign bit_stb_o      = phase;
  assign frame_start_o  = phase && bcnt == 8'h00;
  assign mframe_start_o = frame_start_o && fcnt == 0;
  assign rx_bit_o       = pat[0];
  assign tx_line_o      = pat[1];
  assign tx_bits_o      = pat[4:2];
endmodule // hdlcm_line_model

// [verif/hdlcm_mapper_assertions.sv]
// Port-level checker for the HDLC slot mapper.
`timescale 1ns/1ns
module hdlcm_mapper_checker (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic       wb_ack_o,
  input  wire logic       line_bit_stb_i,
  input  wire logic       line_tx_bit_i,
  input  wire logic       line_tx_bit_o,
  input  wire logic       rx_valid_o,
  input  wire logic       line_rx_bit_i,
  input  wire logic       rx_bit_o,
  input  wire logic [1:0] rx_chan_o,
  input  wire logic [2:0] tx_bit_i,
  input  wire logic [2:0] tx_take_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_reset_idle: assert property ($fell(rst_i) |-> !wb_ack_o && tx_take_o == 3'h0 && line_tx_bit_o && !rx_valid_o)
    else $error("outputs busy after reset");
  a_take_cause: assert property (tx_take_o != 3'h0 |-> $past(line_bit_stb_i) && !$past(rst_i))
    else $error("take without strobe");
  a_take_one_chan: assert property ($onehot0(tx_take_o))
    else $error("two channels took one bit");
  a_tx_owner_bit: assert property (tx_take_o != 3'h0 |-> line_tx_bit_o == |(tx_take_o & $past(tx_bit_i)))
    else $error("wrong channel bit inserted");
  a_tx_pass_through: assert property ($past(line_bit_stb_i) && !$past(rst_i) && tx_take_o == 3'h0
    |-> line_tx_bit_o == $past(line_tx_bit_i))
    else $error("framer bit not passed");
  a_tx_hold_bit: assert property (!$past(line_bit_stb_i) && !$past(rst_i) |-> $stable(line_tx_bit_o))
    else $error("tx bit moved between strobes");
  a_rx_cause: assert property ($rose(rx_valid_o) |-> $past(line_bit_stb_i))
    else $error("rx word without strobe");
  a_rx_chan_range: assert property (rx_valid_o |-> rx_chan_o != 2'h3)
    else $error("bad rx channel");
  // The bench pops at once except in the overrun test; a rising valid means the push landed in an empty buffer and shows at the head.
  a_rx_bit_copy: assert property ($rose(rx_valid_o) |-> rx_bit_o == $past(line_rx_bit_i))
    else $error("rx bit not passed");

  c_write: cover property (wb_ack_o && wb_we_i);
  c_take_ch3: cover property (tx_take_o[2]);
  c_take_ch1: cover property (tx_take_o[0]);
endmodule // hdlcm_mapper_checker

// [verif/testbench.sv]
// Self-checking bench for the HDLC slot mapper.
`timescale 1ns/1ns
module testbench;
  import hdlcm_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, rx_rdy, stbb, fs, mfs, rxb, ltx, ltxo, rxv, rxo;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic [1:0]  rxc;
  logic [2:0]  txb, take;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          tc[3], rc[4];

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  hdlcm_line_model line (.clk_i(clk_i), .rst_i(rst_i), .bit_stb_o(stbb), .frame_start_o(fs),
    .mframe_start_o(mfs), .rx_bit_o(rxb), .tx_line_o(ltx), .tx_bits_o(txb));
  hdlcm_mapper dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .line_bit_stb_i(stbb), .line_frame_start_i(fs), .line_mframe_start_i(mfs),
    .line_rx_bit_i(rxb), .line_tx_bit_i(ltx), .line_tx_bit_o(ltxo), .rx_valid_o(rxv),
    .rx_ready_i(rx_rdy), .rx_chan_o(rxc), .rx_bit_o(rxo), .tx_bit_i(txb), .tx_take_o(take));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic fail(input string m);
    n_mismatch++;
    $display("FAIL %0t %s", $time, m);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", m, got, exp));
  endtask

  task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                    input logic [3:0] s);
    int i;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {2'h0, idx, 2'h0};
    wdat <= d;
    sel  <= s;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      fail("no ack");
      tally_and_finish();
    end
  endtask

  // Counts over three frames from a multiframe start: odd, even, odd.
  task automatic measure(input int e1t, input int e1r, input int e2, input int e3);
    int i;
    int k;
    int f1;
    tc = '{0, 0, 0};
    rc = '{0, 0, 0, 0};
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (!(mfs && stbb) && i < 3000);
    if (i >= 3000) begin
      fail("no multiframe");
      tally_and_finish();
    end
    k  = 0;
    f1 = -1;
    repeat (1536) begin
      @(posedge clk_i);
      k++;
      if (take[0] === 1'b1 && f1 < 0) f1 = k;
      for (i = 0; i < 3; i++) tc[i] += int'(take[i] === 1'b1);
      if (rxv === 1'b1 && rx_rdy === 1'b1) rc[rxc] += 1;
    end
    chk(tc[0], e1t, "ch1 tx");
    chk(rc[0], e1r, "ch1 rx");
    chk(tc[1], e2, "ch2 tx");
    chk(rc[1], e2, "ch2 rx");
    chk(tc[2], e3, "ch3 tx");
    chk(rc[2], e3, "ch3 rx");
    // Channel 1 sends in slot 3 under mask 0f, so its first bit is position 3,
    // frame bit 28, whose take shows 57 cycles after the frame's first strobe.
    if (e1t > 0) chk(f1 % 512, 57, "ch1 bit order");
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    int i;
    for (i = 0; i < 6; i++) begin
      wb(1'b0, HDLCM_IDX_PARITY + 8'(i), 32'h0, 4'hf);
      chk(q, (i > 0 && i < 4) ? 32'hff : 32'h0, "reset value");
    end
    wb(1'b1, 8'hc0, 32'h5a, 4'hf);
    wb(1'b0, 8'hc0, 32'h0, 4'hf);
    chk(q, 32'h0, "unmapped read");
    wb(1'b1, HDLCM_IDX_MASK2, 32'h5a, 4'h1);
    wb(1'b0, HDLCM_IDX_MASK2, 32'h0, 4'hf);
    chk(q, 32'h5a, "mask readback");
    measure(0, 0, 0, 0);
  endtask

  task automatic t_parity();
    int p;
    int n[4] = '{3, 2, 1, 0};
    wb(1'b1, HDLCM_IDX_MASK1, 32'h0f, 4'h1);
    wb(1'b1, HDLCM_IDX_MASK2, 32'h81, 4'h1);
    wb(1'b1, HDLCM_IDX_CODE2, 32'h05, 4'h1);
    wb(1'b1, HDLCM_IDX_CODE3, 32'h1e, 4'h1);
    wb(1'b1, HDLCM_IDX_TXEN1, 32'h8, 4'hf);
    wb(1'b1, HDLCM_IDX_RXEN1, 32'h600, 4'hf);
    for (p = 0; p < 4; p++) begin
      wb(1'b1, HDLCM_IDX_PARITY, {26'h0, {3{p[1:0]}}}, 4'h1);
      measure(4 * n[p], 8 * n[p], 2 * n[p], 8 * n[p]);
    end
  endtask

  task automatic t_overrun();
    int i;
    wb(1'b1, HDLCM_IDX_PARITY, 32'h0, 4'h1);
    rx_rdy <= 1'b0;
    repeat (1200) @(posedge clk_i);
    chk({31'h0, rxv}, 32'h1, "valid while stalled");
    wb(1'b0, HDLCM_IDX_STATUS, 32'h0, 4'hf);
    chk(q & 32'h001f_0200, 32'h0010_0200, "full and overrun");
    rx_rdy <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (rxv !== 1'b0 && i < 100);
    chk({31'h0, rxv}, 32'h0, "drained");
    if (rxv !== 1'b0) tally_and_finish();
    wb(1'b1, HDLCM_IDX_STATUS, 32'h200, 4'h2);
    wb(1'b0, HDLCM_IDX_STATUS, 32'h0, 4'hf);
    chk(q & 32'h200, 32'h0, "overrun cleared");
  endtask

  initial begin
    rst_i  = 1'b1;
    cyc    = 1'b0;
    stb    = 1'b0;
    we     = 1'b0;
    adr    = 12'h000;
    sel    = 4'h0;
    wdat   = 32'h0;
    rx_rdy = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_parity();
    t_overrun();
    tally_and_finish();
  end
endmodule // testbench

bind hdlcm_mapper hdlcm_mapper_checker u_checker (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
  .line_bit_stb_i(line_bit_stb_i), .line_tx_bit_i(line_tx_bit_i),
  .line_tx_bit_o(line_tx_bit_o), .rx_valid_o(rx_valid_o), .rx_chan_o(rx_chan_o),
  .line_rx_bit_i(line_rx_bit_i), .rx_bit_o(rx_bit_o),
  .tx_bit_i(tx_bit_i), .tx_take_o(tx_take_o));
